// ---- rtl/counter_timer_pkg.sv ----
// Constants, register map and field layouts for the counter/timer block.
// Assumes an APB slave with byte addresses and 32-bit data words.
`default_nettype none

package counter_timer_pkg;

  // ==========================================================
  // Bus and register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFF_TIMER_MODE = 8'h04;
  localparam logic [7:0] OFF_CLOCK_CONTROL = 8'h08;
  localparam logic [7:0] OFF_TIMER0_COUNT = 8'h10;
  localparam logic [7:0] OFF_TIMER1_COUNT = 8'h14;
  localparam logic [7:0] OFF_SECOND_TIMER_CONTROL = 8'hC8;
  localparam logic [7:0] OFF_SECOND_TIMER_COUNT = 8'hCC;
  localparam logic [7:0] OFF_SECOND_TIMER_HOLD = 8'hD0;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hD4;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'hD8;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'hDC;

  // ==========================================================
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int RUN0_BIT = 4;
  localparam int RUN_STRIDE = 2;
  localparam int TIMER0_GATE_SELECT_BIT = 3;
  localparam int MODE0_LSB = 0;
  localparam int MODE_STRIDE = 4;
  localparam int T0M_BIT = 3;
  localparam int T2M_BIT = 5;
  localparam logic [1:0] MODE_13BIT = 2'h0;

  // ==========================================================
  // Interrupt status layout
  localparam int IRQ_W = 3;
  localparam int IRQ_T0 = 0;
  localparam int IRQ_T1 = 1;
  localparam int IRQ_T2 = 2;

  // ==========================================================
  // Timing
  localparam logic [3:0] PRESCALE_LAST = 4'hB;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // ==========================================================
  // Types
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic uart_rx_clock_select;
    logic uart_tx_clock_select;
    logic trigger_pin_enable;
    logic run_bit;
    logic count_or_time_select;
    logic capture_reload_select;
  } second_timer_control_t;

  typedef struct packed {
    logic level;
    logic fall;
  } pin_state_t;

endpackage

`default_nettype wire

// ---- rtl/pin_edge_sync.sv ----
// Two-flop synchroniser with falling-edge detection for one pin.
// Assumes the pin idles at IDLE_LEVEL so reset makes no false edge.
`default_nettype none

module pin_edge_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_in,
  output var counter_timer_pkg::pin_state_t pin_out
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // ==========================================================
  // Synchroniser and edge history
  // sync then edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= IDLE_LEVEL;
      sync_reg <= IDLE_LEVEL;
      prev_reg <= IDLE_LEVEL;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Only the second and third stages feed the detector
  assign pin_out.level = sync_reg;
  assign pin_out.fall = prev_reg & ~sync_reg;

endmodule

`default_nettype wire

// ---- rtl/gated_counter_timers.sv ----
// Timers 0 and 1 (13/16-bit, gated) and timer 2 (capture/reload, baud).
// Assumes an APB master on clk_sys and free-running external pins.
`default_nettype none

module gated_counter_timers (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_gate_input0,
  input wire logic external_gate_input1,
  input wire logic capture_trigger_pin,
  input wire logic second_timer_count_pin,
  output logic irq,
  output logic uart_rx_baud_tick,
  output logic uart_tx_baud_tick
);

  // ==========================================================
  // Declarations
  counter_timer_pkg::pin_state_t gate_pin [2];
  counter_timer_pkg::pin_state_t trig_pin;
  counter_timer_pkg::pin_state_t cnt_pin;
  counter_timer_pkg::second_timer_control_t t2_ctrl_reg;
  counter_timer_pkg::second_timer_control_t t2_ctrl_next;
  logic [7:0] timer_control_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] clock_control_reg;
  logic [15:0] tcnt_reg [2];
  logic [1:0] tcnt_en;
  logic [1:0] tcnt_wr;
  logic [1:0] tcnt_ovf;
  logic [1:0] tcnt_tick;
  logic [15:0] t2_cnt_reg;
  logic [15:0] t2_hold_reg;
  logic [3:0] pre_reg;
  logic pre_tick;
  logic [counter_timer_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [counter_timer_pkg::IRQ_W-1:0] irq_en_reg;
  logic [counter_timer_pkg::IRQ_W-1:0] irq_evt;
  logic [counter_timer_pkg::IRQ_W-1:0] irq_clr;
  logic irq_reg;
  logic rx_tick_reg;
  logic tx_tick_reg;
  logic bus_wr;
  logic setup;
  logic [31:0] rd_next;
  logic rd_err;
  logic baud;
  logic capture_mode;
  logic t2_tick;
  logic t2_run_tick;
  logic t2_ovf;
  logic trig_evt;
  logic t2_cnt_wr;
  logic t2_hold_wr;
  logic t2_ctrl_wr;

  // ==========================================================
  // Pin synchronisers
  pin_edge_sync #(.IDLE_LEVEL(1'b1)) u_timer0_gate_select (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(external_gate_input0),
    .pin_out(gate_pin[0])
  );

  pin_edge_sync #(.IDLE_LEVEL(1'b1)) u_gate1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(external_gate_input1),
    .pin_out(gate_pin[1])
  );

  pin_edge_sync #(.IDLE_LEVEL(1'b1)) u_trig (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(capture_trigger_pin),
    .pin_out(trig_pin)
  );

  pin_edge_sync #(.IDLE_LEVEL(1'b1)) u_count (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(second_timer_count_pin),
    .pin_out(cnt_pin)
  );

  // ==========================================================
  // APB slave
  // One wait-free access cycle; read data sampled at setup
  assign setup = psel & ~penable;
  assign bus_wr = psel & penable & pready & pwrite;

  always_comb
  begin
    rd_next = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      counter_timer_pkg::OFF_TIMER_CONTROL: rd_next[7:0] = timer_control_reg;
      counter_timer_pkg::OFF_TIMER_MODE: rd_next[7:0] = timer_mode_reg;
      counter_timer_pkg::OFF_CLOCK_CONTROL: rd_next[7:0] = clock_control_reg;
      counter_timer_pkg::OFF_TIMER0_COUNT: rd_next[15:0] = tcnt_reg[0];
      counter_timer_pkg::OFF_TIMER1_COUNT: rd_next[15:0] = tcnt_reg[1];
      counter_timer_pkg::OFF_SECOND_TIMER_CONTROL: rd_next[7:0] = t2_ctrl_reg;
      counter_timer_pkg::OFF_SECOND_TIMER_COUNT: rd_next[15:0] = t2_cnt_reg;
      counter_timer_pkg::OFF_SECOND_TIMER_HOLD: rd_next[15:0] = t2_hold_reg;
      counter_timer_pkg::OFF_IRQ_STATUS:
        rd_next[counter_timer_pkg::IRQ_W-1:0] = irq_stat_reg;
      counter_timer_pkg::OFF_IRQ_CLEAR: rd_next = 32'h0000_0000;
      counter_timer_pkg::OFF_IRQ_ENABLE:
        rd_next[counter_timer_pkg::IRQ_W-1:0] = irq_en_reg;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      prdata <= (setup & ~pwrite) ? rd_next : 32'h0000_0000;
      pslverr <= setup & rd_err;
    end
  end

  // ==========================================================
  // Timer 0/1 control registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_control_reg <= counter_timer_pkg::BYTE_RESET;
      timer_mode_reg <= counter_timer_pkg::BYTE_RESET;
      clock_control_reg <= counter_timer_pkg::BYTE_RESET;
    end
    else if (bus_wr)
    begin
      if (paddr == counter_timer_pkg::OFF_TIMER_CONTROL)
        timer_control_reg <= pwdata[7:0];
      if (paddr == counter_timer_pkg::OFF_TIMER_MODE)
        timer_mode_reg <= pwdata[7:0];
      if (paddr == counter_timer_pkg::OFF_CLOCK_CONTROL)
        clock_control_reg <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Divide-by-twelve timebase
  assign pre_tick = (pre_reg == counter_timer_pkg::PRESCALE_LAST);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pre_reg <= 4'h0;
    else if (pre_tick)
      pre_reg <= 4'h0;
    else
      pre_reg <= pre_reg + 4'h1;
  end

  // ==========================================================
  // Timers 0 and 1
  // 13-bit mode: high byte plus low five bits; bits 7:5 stay put
  function automatic logic [16:0] bump(input logic [1:0] mode,
                                       input logic [15:0] c);
    logic [13:0] v;
    logic [16:0] w;
    v = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    w = {1'b0, c} + 17'h00001;
    if (mode == counter_timer_pkg::MODE_13BIT)
      bump = {v[13], v[12:5], c[7:5], v[4:0]};
    else
      bump = w;
  endfunction

  for (genvar i = 0; i < 2; i++)
  begin : g_timer
    logic [1:0] mode;
    logic gate_sel;
    logic run;
    logic [16:0] bumped;

    assign mode = timer_mode_reg[counter_timer_pkg::MODE0_LSB
                  + counter_timer_pkg::MODE_STRIDE*i +: 2];
    assign gate_sel = timer_mode_reg[counter_timer_pkg::TIMER0_GATE_SELECT_BIT
                      + counter_timer_pkg::MODE_STRIDE*i];
    assign run = timer_control_reg[counter_timer_pkg::RUN0_BIT
                 + counter_timer_pkg::RUN_STRIDE*i];
    assign tcnt_tick[i] = clock_control_reg[counter_timer_pkg::T0M_BIT + i]
                          | pre_tick;
    assign tcnt_en[i] = run & (~gate_sel | gate_pin[i].level);
    assign tcnt_wr[i] = bus_wr & (paddr == (i == 0
                        ? counter_timer_pkg::OFF_TIMER0_COUNT
                        : counter_timer_pkg::OFF_TIMER1_COUNT));
    assign bumped = bump(mode, tcnt_reg[i]);
    assign tcnt_ovf[i] = tcnt_en[i] & tcnt_tick[i] & bumped[16] & ~tcnt_wr[i];

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        tcnt_reg[i] <= counter_timer_pkg::COUNT_RESET;
      else if (tcnt_wr[i])
        tcnt_reg[i] <= pwdata[15:0];
      else if (tcnt_en[i] & tcnt_tick[i])
        tcnt_reg[i] <= bumped[15:0];
    end
  end

  // ==========================================================
  // Timer 2 datapath
  // baud forces reload
  assign baud = t2_ctrl_reg.uart_rx_clock_select
                | t2_ctrl_reg.uart_tx_clock_select;
  assign capture_mode = t2_ctrl_reg.capture_reload_select & ~baud;
  assign t2_tick = t2_ctrl_reg.count_or_time_select ? cnt_pin.fall
                   : (clock_control_reg[counter_timer_pkg::T2M_BIT]
                      | pre_tick);
  assign t2_run_tick = t2_ctrl_reg.run_bit & t2_tick;
  assign t2_ovf = t2_run_tick & (t2_cnt_reg == counter_timer_pkg::COUNT_TOP);
  assign trig_evt = trig_pin.fall & t2_ctrl_reg.trigger_pin_enable & ~baud;
  assign t2_cnt_wr = bus_wr
                     & (paddr == counter_timer_pkg::OFF_SECOND_TIMER_COUNT);
  assign t2_hold_wr = bus_wr
                      & (paddr == counter_timer_pkg::OFF_SECOND_TIMER_HOLD);
  assign t2_ctrl_wr = bus_wr
                      & (paddr == counter_timer_pkg::OFF_SECOND_TIMER_CONTROL);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      t2_cnt_reg <= counter_timer_pkg::COUNT_RESET;
    else if (t2_cnt_wr)
      t2_cnt_reg <= pwdata[15:0];
    else if (trig_evt & ~capture_mode)
      t2_cnt_reg <= t2_hold_reg;
    else if (t2_ovf)
      t2_cnt_reg <= capture_mode ? counter_timer_pkg::COUNT_RESET
                                 : t2_hold_reg;
    else if (t2_run_tick)
      t2_cnt_reg <= t2_cnt_reg + counter_timer_pkg::COUNT_ONE;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      t2_hold_reg <= counter_timer_pkg::COUNT_RESET;
    else if (t2_hold_wr)
      t2_hold_reg <= pwdata[15:0];
    else if (trig_evt & capture_mode)
      t2_hold_reg <= t2_cnt_reg;
  end

  // ==========================================================
  // Timer 2 control and flags
  // Hardware set wins over a software clear in the same cycle
  always_comb
  begin
    t2_ctrl_next = t2_ctrl_wr
                   ? counter_timer_pkg::second_timer_control_t'(pwdata[7:0])
                   : t2_ctrl_reg;
    if (t2_ovf & ~baud)
      t2_ctrl_next.overflow_flag = 1'b1;
    if (trig_evt)
      t2_ctrl_next.external_flag = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      t2_ctrl_reg <= counter_timer_pkg::BYTE_RESET;
    else
      t2_ctrl_reg <= t2_ctrl_next;
  end

  // ==========================================================
  // UART baud ticks
  // receive and transmit sources
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_tick_reg <= 1'b0;
      tx_tick_reg <= 1'b0;
    end
    else
    begin
      rx_tick_reg <= t2_ctrl_reg.uart_rx_clock_select ? t2_ovf : tcnt_ovf[1];
      tx_tick_reg <= t2_ctrl_reg.uart_tx_clock_select ? t2_ovf : tcnt_ovf[1];
    end
  end

  assign uart_rx_baud_tick = rx_tick_reg;
  assign uart_tx_baud_tick = tx_tick_reg;

  // ==========================================================
  // Interrupts
  // timer 0, 1 and 2 requests
  assign irq_evt[counter_timer_pkg::IRQ_T0] = tcnt_ovf[0];
  assign irq_evt[counter_timer_pkg::IRQ_T1] = tcnt_ovf[1];
  assign irq_evt[counter_timer_pkg::IRQ_T2] =
    (t2_ctrl_next.overflow_flag & ~t2_ctrl_reg.overflow_flag)
    | (t2_ctrl_next.external_flag & ~t2_ctrl_reg.external_flag);
  assign irq_clr = (bus_wr & (paddr == counter_timer_pkg::OFF_IRQ_CLEAR))
                   ? pwdata[counter_timer_pkg::IRQ_W-1:0]
                   : '0;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
      if (bus_wr & (paddr == counter_timer_pkg::OFF_IRQ_ENABLE))
        irq_en_reg <= pwdata[counter_timer_pkg::IRQ_W-1:0];
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  assign irq = irq_reg;

  // ==========================================================
  // Assertions
  sequence s_t2_event_enabled;
    irq_evt[counter_timer_pkg::IRQ_T2]
      && irq_en_reg[counter_timer_pkg::IRQ_T2];
  endsequence

  sequence s_no_bus_write;
    !bus_wr;
  endsequence

  property p_t0_holds;
    @(posedge clk_sys) disable iff (!rst_n)
    (!tcnt_en[0] && !tcnt_wr[0]) |=> tcnt_reg[0] == $past(tcnt_reg[0]);
  endproperty
  a_t0_holds: assert property (p_t0_holds)
    else $error("timer 0 moved while disabled");

  property p_run_keeps_count;
    @(posedge clk_sys) disable iff (!rst_n)
    ($rose(timer_control_reg[counter_timer_pkg::RUN0_BIT])
      && !$past(tcnt_wr[0])) |-> tcnt_reg[0] == $past(tcnt_reg[0]);
  endproperty
  a_run_keeps_count: assert property (p_run_keeps_count)
    else $error("setting run changed timer 0 count");

  property p_t1_13bit;
    @(posedge clk_sys) disable iff (!rst_n)
    (tcnt_en[1] && tcnt_tick[1] && !tcnt_wr[1] && g_timer[1].mode
      == counter_timer_pkg::MODE_13BIT)
      |=> tcnt_reg[1][7:5] == $past(tcnt_reg[1][7:5]);
  endproperty
  a_t1_13bit: assert property (p_t1_13bit)
    else $error("timer 1 13-bit mode touched unused bits");

  property p_t0_16bit;
    @(posedge clk_sys) disable iff (!rst_n)
    (tcnt_en[0] && tcnt_tick[0] && !tcnt_wr[0] && g_timer[0].mode
      != counter_timer_pkg::MODE_13BIT)
      |=> tcnt_reg[0] == $past(tcnt_reg[0]) + counter_timer_pkg::COUNT_ONE;
  endproperty
  a_t0_16bit: assert property (p_t0_16bit)
    else $error("timer 0 16-bit increment wrong");

  property p_tf2_set;
    @(posedge clk_sys) disable iff (!rst_n)
    (t2_ovf && !baud) |=> t2_ctrl_reg.overflow_flag;
  endproperty
  a_tf2_set: assert property (p_tf2_set)
    else $error("overflow flag not set on rollover");

  // Only a register write may drop a flag
  property p_tf2_sticky;
    @(posedge clk_sys) disable iff (!rst_n)
    (t2_ctrl_reg.overflow_flag && !t2_ctrl_wr)
      |=> t2_ctrl_reg.overflow_flag;
  endproperty
  a_tf2_sticky: assert property (p_tf2_sticky)
    else $error("overflow flag cleared by hardware");

  property p_second_timer_external_flag_sticky;
    @(posedge clk_sys) disable iff (!rst_n)
    (t2_ctrl_reg.external_flag && !t2_ctrl_wr)
      |=> t2_ctrl_reg.external_flag;
  endproperty
  a_second_timer_external_flag_sticky: assert property (p_second_timer_external_flag_sticky)
    else $error("external flag cleared by hardware");

  property p_tf2_baud;
    @(posedge clk_sys) disable iff (!rst_n)
    (baud && !t2_ctrl_wr && !t2_ctrl_reg.overflow_flag)
      |=> !t2_ctrl_reg.overflow_flag;
  endproperty
  a_tf2_baud: assert property (p_tf2_baud)
    else $error("overflow flag set in baud mode");

  property p_t2_irq;
    @(posedge clk_sys) disable iff (!rst_n)
    s_t2_event_enabled ##0 s_no_bus_write |-> ##2 irq_reg;
  endproperty
  a_t2_irq: assert property (p_t2_irq)
    else $error("timer 2 interrupt not raised");

  property p_second_timer_external_flag_set;
    @(posedge clk_sys) disable iff (!rst_n)
    trig_evt |=> t2_ctrl_reg.external_flag;
  endproperty
  a_second_timer_external_flag_set: assert property (p_second_timer_external_flag_set)
    else $error("external flag not set on trigger");

  property p_rx_source;
    @(posedge clk_sys) disable iff (!rst_n)
    (t2_ovf && t2_ctrl_reg.uart_rx_clock_select) |=> uart_rx_baud_tick;
  endproperty
  a_rx_source: assert property (p_rx_source)
    else $error("receive tick missing on timer 2 overflow");

  property p_tx_source;
    @(posedge clk_sys) disable iff (!rst_n)
    (tcnt_ovf[1] && !t2_ctrl_reg.uart_tx_clock_select) |=> uart_tx_baud_tick;
  endproperty
  a_tx_source: assert property (p_tx_source)
    else $error("transmit tick missing on timer 1 overflow");

  property p_trig_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
    (trig_pin.fall && !t2_ctrl_reg.trigger_pin_enable && !t2_ctrl_wr
      && !t2_ctrl_reg.external_flag) |=> !t2_ctrl_reg.external_flag;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored)
    else $error("disabled trigger set external flag");

  property p_t2_stopped;
    @(posedge clk_sys) disable iff (!rst_n)
    (!t2_ctrl_reg.run_bit && !t2_cnt_wr && !trig_evt)
      |=> $stable(t2_cnt_reg);
  endproperty
  a_t2_stopped: assert property (p_t2_stopped)
    else $error("timer 2 counted while stopped");

  property p_t2_capture;
    @(posedge clk_sys) disable iff (!rst_n)
    (trig_evt && capture_mode && !t2_hold_wr)
      |=> t2_hold_reg == $past(t2_cnt_reg);
  endproperty
  a_t2_capture: assert property (p_t2_capture)
    else $error("capture did not copy count");

  property p_t2_reload;
    @(posedge clk_sys) disable iff (!rst_n)
    ((t2_ovf || trig_evt) && !capture_mode && !t2_cnt_wr)
      |=> t2_cnt_reg == $past(t2_hold_reg);
  endproperty
  a_t2_reload: assert property (p_t2_reload)
    else $error("reload did not load hold value");

endmodule

`default_nettype wire

// ---- verification/ext_pin_model.sv ----
// External pin driver for the counter/timer block: gate, trigger, count.
// Assumes pins with pull-ups, so every pin idles high between pulses.
`default_nettype none

module ext_pin_model (
  input wire logic clk_sys,
  output logic timer0_gate_select,
  output logic gate1,
  output logic trig,
  output logic cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    timer0_gate_select = 1'b1;
    gate1 = 1'b1;
    trig = 1'b1;
    cnt = 1'b1;
  end

  // ==========================================================
  // Pin tasks
  task automatic set_timer0_gate_select(input logic v);
    @(posedge clk_sys);
    timer0_gate_select <= v;
  endtask

  // Pulses held 4 cycles, longer than the synchroniser needs
  task automatic fall_trig();
    @(posedge clk_sys);
    trig <= 1'b0;
    repeat (4) @(posedge clk_sys);
    trig <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic fall_cnt();
    @(posedge clk_sys);
    cnt <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cnt <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

// ---- verification/gated_counter_timers_tb.sv ----
// Self-checking bench for the gated counter/timer block.
// Assumes the APB slave answers in one access cycle; pins from the model.
`default_nettype none

module gated_counter_timers_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, rx_tick, tx_tick;
  logic g0, g1, trig, cnt, err;
  logic [31:0] q;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int tx_n = 0;
  int rx_n = 0;

  always #20 clk_sys = ~clk_sys;

  gated_counter_timers gated_counter_timers_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_gate_input0(g0),
    .external_gate_input1(g1), .capture_trigger_pin(trig),
    .second_timer_count_pin(cnt), .irq(irq),
    .uart_rx_baud_tick(rx_tick), .uart_tx_baud_tick(tx_tick)
  );

  ext_pin_model ext_pin_model_inst (
    .clk_sys(clk_sys), .timer0_gate_select(g0), .gate1(g1), .trig(trig), .cnt(cnt)
  );

  // ==========================================================
  // Bus and compare tasks
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_ok(input logic ok);
    tests_run++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD t=%0t condition false", $time);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    tx_n <= tx_n + (tx_tick === 1'b1);
    rx_n <= rx_n + (rx_tick === 1'b1);
    if (++cyc > 5000)
    begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // Scenarios
  task automatic t_gate();
    apb(1, 8'h08, 32'h28);
    apb(1, 8'h04, 32'h09);
    apb(1, 8'h10, 32'h0100);
    ext_pin_model_inst.set_timer0_gate_select(1'b0);
    apb(1, 8'h00, 32'h10);
    repeat (20) @(posedge clk_sys);
    apb(0, 8'h10, 32'h0);
    chk(q, 32'h0100);
    ext_pin_model_inst.set_timer0_gate_select(1'b1);
    repeat (20) @(posedge clk_sys);
    apb(0, 8'h10, 32'h0);
    chk_ok(q > 32'h0100 && q < 32'h0140);
    apb(1, 8'h00, 32'h0);
    $display("gate test done");
  endtask

  task automatic t_reload();
    apb(1, 8'hD0, 32'h1234);
    apb(1, 8'hCC, 32'hFFF0);
    apb(1, 8'hDC, 32'h4);
    apb(1, 8'hC8, 32'h04);
    repeat (40) @(posedge clk_sys);
    apb(0, 8'hC8, 32'h0);
    chk(q & 32'h80, 32'h80);
    apb(0, 8'hCC, 32'h0);
    chk_ok(q >= 32'h1234 && q < 32'h1270);
    chk(irq, 1'b1);
    apb(1, 8'hC8, 32'h00);
    apb(1, 8'hD8, 32'h4);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0);
    apb(0, 8'hC8, 32'h0);
    chk(q, 32'h00);
    $display("reload test done");
  endtask

  task automatic t_capture();
    apb(1, 8'hCC, 32'h0500);
    apb(1, 8'hC8, 32'h0D);
    ext_pin_model_inst.fall_trig();
    apb(0, 8'hC8, 32'h0);
    chk(q & 32'h40, 32'h40);
    apb(0, 8'hD0, 32'h0);
    chk_ok(q > 32'h0500 && q < 32'h0540);
    apb(1, 8'hC8, 32'h05);
    ext_pin_model_inst.fall_trig();
    apb(0, 8'hC8, 32'h0);
    chk(q & 32'h40, 32'h00);
    apb(1, 8'hC8, 32'h08);
    apb(1, 8'hD0, 32'h0ABC);
    ext_pin_model_inst.fall_trig();
    apb(0, 8'hCC, 32'h0);
    chk(q, 32'h0ABC);
    $display("capture test done");
  endtask

  task automatic t_counter_and_baud();
    apb(1, 8'hC8, 32'h06);
    apb(1, 8'hCC, 32'h0);
    repeat (3) ext_pin_model_inst.fall_cnt();
    apb(0, 8'hCC, 32'h0);
    chk(q, 32'h3);
    apb(1, 8'hD0, 32'hFFF0);
    apb(1, 8'hCC, 32'hFFF0);
    apb(1, 8'hC8, 32'h35);
    repeat (60) @(posedge clk_sys);
    apb(0, 8'hC8, 32'h0);
    chk(q & 32'h80, 32'h00);
    chk_ok(tx_n > 0 && tx_n == rx_n);
    apb(0, 8'h40, 32'h0);
    chk(err, 1'b1);
    $display("counter and baud test done");
  endtask

  // 13-bit timer 1 from 0xFFFE: one overflow, bits 7:5 kept
  task automatic t_timer1();
    int tx0;
    int rx0;
    apb(1, 8'hC8, 32'h00);
    apb(1, 8'h08, 32'h10);
    apb(1, 8'h04, 32'h00);
    apb(1, 8'h14, 32'hFFFE);
    tx0 = tx_n;
    rx0 = rx_n;
    apb(1, 8'h00, 32'h40);
    repeat (10) @(posedge clk_sys);
    apb(1, 8'h00, 32'h00);
    apb(0, 8'h14, 32'h0);
    chk(q & 32'hFFE0, 32'h00E0);
    chk(tx_n - tx0, 1);
    chk(rx_n - rx0, 1);
    $display("timer 1 test done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(0, 8'hC8, 32'h0);
    chk(q, 32'h0);
    t_gate();
    t_reload();
    t_capture();
    t_counter_and_baud();
    t_timer1();
    end_sim();
  end
endmodule

`default_nettype wire
